// [dv/dspm_mem_model.sv]
// external asynchronous memory on the far side of the parallel port
// assumes active-low strobes and a 16-word array indexed by ext_addr[3:0]
`timescale 1ns/10ps
`default_nettype none
module dspm_mem_model
  import dspm_pkg::*;
(
  input wire logic pclk,
  input wire logic mode,
  input wire logic mem_n,
  input wire logic io_n,
  input wire logic dir,
  input wire logic [EXT_AW-1:0] addr,
  input wire logic [EXT_DW-1:0] wdata,
  input wire logic [9:0] hold,
  output logic ready,
  output logic [EXT_DW-1:0] rdata
);
  logic [EXT_DW-1:0] mem [16];
  logic [EXT_DW-1:0] last = '0;
  logic [9:0] cnt = '0;
  wire logic act = mode && !(mem_n && io_n);
  // ready held low until the access has stood for hold cycles
  assign ready = act && cnt >= hold;
  // released bus shows the inverse so stale data never passes
  assign rdata = (act && dir) ? mem[addr[3:0]] : ~last;
  always @(posedge pclk)
  begin
    cnt <= act ? cnt + 10'h1 : 10'h0;
    if (act && dir)
      last <= mem[addr[3:0]];
    if (act && !dir)
      mem[addr[3:0]] <= wdata;
  end
endmodule
`default_nettype wire

// [dv/dspm_port_test.sv]
// self-checking bench for dspm_port: APB register tasks and pin checks
// assumes dspm_mem_model answers on the external memory side
`timescale 1ns/10ps
`default_nettype none
module dspm_port_test;
  import dspm_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, perr;
  logic pmode = 1, hmux = 0, ssel = 0, odis_n = 1, dir_in = 0, p3_in = 0, tmr = 0;
  logic ready_in, ready_out, ready_oe_n, dir_out, dir_oe_n, io_n, io_oe_n;
  logic ps_n, ds_n, ms_n, mc_oe_n, xd_oe_n, mclk, mclk_oe_n;
  logic [EXT_AW-1:0] xa;
  logic [EXT_DW-1:0] xw, xr;
  logic [9:0] hold = '0;
  int n_fail = 0, n_compared = 0;
  time t0;
  initial forever #2.5 pclk = ~pclk;
  dspm_port i_dspm_port (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .port_mode_pin(pmode), .host_mux_select(hmux),
    .subsystem_select(ssel), .output_disable_n(odis_n), .ready_in(ready_in),
    .ready_out(ready_out), .ready_oe_n(ready_oe_n), .dir_in(dir_in), .dir_out(dir_out),
    .dir_oe_n(dir_oe_n), .subsystem_a_pin3_io_in(p3_in), .io_space_strobe_n(io_n),
    .io_space_strobe_oe_n(io_oe_n), .subsystem_a_timer_output(tmr),
    .program_space_select_n(ps_n), .data_space_select_n(ds_n), .memory_strobe_n(ms_n),
    .mem_ctl_oe_n(mc_oe_n), .ext_addr(xa), .ext_wdata(xw), .ext_data_oe_n(xd_oe_n),
    .ext_rdata(xr), .machine_clock_output(mclk), .machine_clock_oe_n(mclk_oe_n));
  dspm_mem_model i_dspm_mem_model (.pclk(pclk), .mode(pmode), .mem_n(ms_n), .io_n(io_n),
    .dir(dir_out), .addr(xa), .wdata(xw), .hold(hold), .ready(ready_in), .rdata(xr));
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_fail++;
      $display("ERROR %0t: no bus answer", $time);
      finish_test();
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(rd & m, e);
  endtask
  // bounded poll; a stuck access ends the run
  task automatic idle;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, OFF_STATUS, '0);
      n++;
    end
    while (rd[ST_BUSY_BIT] !== 1'b0 && n < 60);
    if (n >= 60)
    begin
      n_fail++;
      $display("ERROR %0t: access never ended", $time);
      finish_test();
    end
  endtask
  task automatic rise;
    int n;
    n = 0;
    while (mclk !== 1'b0 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    while (mclk !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20)
    begin
      n_fail++;
      $display("ERROR %0t: machine clock stuck", $time);
      finish_test();
    end
  endtask
  initial
  begin
    cyc(6);
    presetn <= 1'b1;
    cyc(2);
    rc(OFF_PMODE, 32'hff, 32'h2);
    apb(1'b0, 8'h1c, '0);
    chk({rd[30:0], perr}, 32'h1);
    rise();
    t0 = $time;
    rise();
    chk(32'($time - t0), 32'd20);
    apb(1'b1, OFF_WDATA, 32'ha5c3);
    apb(1'b1, OFF_ADDR, 32'h5);
    apb(1'b1, OFF_CMD, 32'h5);
    cyc(1);
    chk(32'({ds_n, ps_n, ms_n, dir_out, io_n, xd_oe_n}), 32'h12);
    chk(32'(xa), 32'h5);
    chk(32'(xw), 32'ha5c3);
    idle();
    chk(32'({ds_n, ms_n, dir_out}), 32'h7);
    apb(1'b1, OFF_CMD, 32'h0);
    cyc(1);
    chk(32'({ps_n, ds_n, dir_out}), 32'h3);
    idle();
    rc(OFF_RDATA, 32'hffffffff, 32'ha5c3);
    apb(1'b1, OFF_CMD, 32'h6);
    cyc(1);
    chk(32'({io_n, ms_n, dir_out}), 32'h2);
    idle();
    apb(1'b1, OFF_WDATA, 32'h1234);
    apb(1'b1, OFF_ADDR, 32'h3);
    apb(1'b1, OFF_CMD, 32'he);
    cyc(1);
    chk(32'({io_n, ms_n}), 32'h3);
    idle();
    apb(1'b1, OFF_WDATA, 32'h0);
    apb(1'b1, OFF_CMD, 32'ha);
    idle();
    rc(OFF_RDATA, 32'hffffffff, 32'h1234);
    apb(1'b1, OFF_PMODE, 32'h22);
    hold <= 10'h3ff;
    apb(1'b1, OFF_CMD, 32'h1);
    cyc(40);
    rc(OFF_STATUS, 32'h1, 32'h1);
    hold <= 10'h0;
    idle();
    apb(1'b1, OFF_PMODE, 32'h12);
    hold <= 10'h3ff;
    apb(1'b1, OFF_CMD, 32'h1);
    idle();
    hold <= 10'h0;
    apb(1'b1, OFF_CMD, 32'h11);
    cyc(1);
    chk(32'(ds_n), 32'h1);
    rc(OFF_STATUS, 32'h3, 32'h2);
    apb(1'b1, OFF_STATUS, 32'h2);
    ssel <= 1'b1;
    cyc(2);
    apb(1'b1, OFF_CMD, 32'h11);
    cyc(1);
    chk(32'(ds_n), 32'h0);
    idle();
    rc(OFF_STATUS, 32'ha, 32'h8);
    apb(1'b1, OFF_PMODE, 32'h3);
    cyc(2);
    chk(32'(mclk_oe_n), 32'h1);
    apb(1'b1, OFF_PMODE, 32'h2);
    odis_n <= 1'b0;
    cyc(2);
    chk(32'({dir_oe_n, io_oe_n, mclk_oe_n, mc_oe_n}), 32'hf);
    odis_n <= 1'b1;
    pmode <= 1'b0;
    dir_in <= 1'b1;
    p3_in <= 1'b1;
    cyc(2);
    chk(32'({ready_oe_n, dir_oe_n, mc_oe_n}), 32'h3);
    rc(OFF_STATUS, 32'h3c, 32'h18);
    rc(OFF_HOSTIO, 32'h10, 32'h10);
    apb(1'b1, OFF_HOSTIO, 32'h7);
    cyc(2);
    chk(32'({ready_out, io_oe_n, io_n}), 32'h5);
    apb(1'b1, OFF_HOSTIO, 32'hd);
    cyc(2);
    chk(32'(io_n), 32'h0);
    tmr <= 1'b1;
    cyc(2);
    chk(32'(io_n), 32'h1);
    apb(1'b1, OFF_CMD, 32'h11);
    rc(OFF_STATUS, 32'h2, 32'h2);
    presetn <= 1'b0;
    pmode <= 1'b1;
    hmux <= 1'b1;
    cyc(2);
    presetn <= 1'b1;
    cyc(2);
    rc(OFF_PMODE, 32'hff, 32'h2);
    rc(OFF_STATUS, 32'h2e, 32'h2c);
    finish_test();
  end
endmodule
`default_nettype wire

// [hw/dspm_pkg.sv]
// constants and types for the dual-subsystem parallel memory port
// assumes a 200 MHz pclk and an APB master with 32-bit data
package dspm_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_PMODE = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_ADDR = 8'h08;
  localparam logic [7:0] OFF_WDATA = 8'h0c;
  localparam logic [7:0] OFF_RDATA = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_HOSTIO = 8'h18;
  // processor_mode_reg fields
  localparam int PM_CYCLE_CLOCK_DISABLE_BIT = 0;
  localparam int PM_BOOT_BIT = 1;
  localparam int PM_WAIT_LSB = 4;
  localparam int WAIT_W = 4;
  localparam logic [3:0] PM_WAIT_RST = 4'h0;
  localparam logic [3:0] READY_MIN_WAIT = 4'h2;
  // command fields
  localparam int CMD_SPACE_LSB = 0;
  localparam int CMD_WRITE_BIT = 2;
  localparam int CMD_DMA_BIT = 3;
  localparam int CMD_SUB_BIT = 4;
  localparam logic [1:0] SP_PROG = 2'h0;
  localparam logic [1:0] SP_DATA = 2'h1;
  localparam logic [1:0] SP_IO = 2'h2;
  // status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ERR_BIT = 1;
  localparam int ST_MODE_BIT = 2;
  localparam int ST_SUB_BIT = 3;
  localparam int ST_HDIR_BIT = 4;
  localparam int ST_HMUX_BIT = 5;
  // host-port pin control fields
  localparam int HIO_RDY_BIT = 0;
  localparam int HIO_VAL_BIT = 1;
  localparam int HIO_OUT_BIT = 2;
  localparam int HIO_TSEL_BIT = 3;
  // widths and depths
  localparam int EXT_AW = 18;
  localparam int EXT_DW = 16;
  localparam int DMAIO_DEPTH = 16;
  // machine cycle timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int MCYC_NS = 20;
  localparam int MCYC_DIV = MCYC_NS / CLK_PERIOD_NS;
  localparam logic [1:0] MCYC_LAST = 2'(MCYC_DIV - 1);
  localparam logic [1:0] MCYC_HALF = 2'(MCYC_DIV / 2);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} dspm_state_t;
endpackage

// [hw/dspm_port.sv]
// parallel memory port control shared by two subsystems, APB registers
// assumes pins synchronous to pclk; three-state pins resolved outside
`timescale 1ns/10ps
`default_nettype none
// How it works
// R1: ready low stalls, resampled each machine cycle
// R2: ready checked only with two or more waits
// R3: external device raises ready when done
// R4: direction output high except during writes
// R5: host mode makes direction pin an input
// R6: host mode drives ready pin as host ready
// R7: io strobe only for CPU io accesses
// R8: DMA io space is internal, CPU unreachable
// R9: host mode turns io strobe into pin3
// R10: select pin picks owning subsystem A/B
// R11: select pin names host-reachable subsystem
// R12: boot bit loaded from mode pins at reset
// R13: output disable floats direction and io strobe
// R14: machine clock falls at each cycle start
// R15: clock disable bit or output disable floats clock
// R16: port mode pin low host, high memory
// R17: program/data selects follow access space
// R18: memory strobes driven only in memory mode
// R19: strobes released cycle after access completes
module dspm_port
  import dspm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic port_mode_pin,
  input wire logic host_mux_select,
  input wire logic subsystem_select,
  input wire logic output_disable_n,
  input wire logic ready_in,
  output logic ready_out,
  output logic ready_oe_n,
  input wire logic dir_in,
  output logic dir_out,
  output logic dir_oe_n,
  input wire logic subsystem_a_pin3_io_in,
  output logic io_space_strobe_n,
  output logic io_space_strobe_oe_n,
  input wire logic subsystem_a_timer_output,
  output logic program_space_select_n,
  output logic data_space_select_n,
  output logic memory_strobe_n,
  output logic mem_ctl_oe_n,
  output logic [EXT_AW-1:0] ext_addr,
  output logic [EXT_DW-1:0] ext_wdata,
  output logic ext_data_oe_n,
  input wire logic [EXT_DW-1:0] ext_rdata,
  output logic machine_clock_output,
  output logic machine_clock_oe_n
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // arbitrary combination; mode pins pick on-chip or external boot
  function automatic logic boot_fn(input logic pm, input logic hm, input logic sel);
    return pm & (hm | ~sel);
  endfunction

  dspm_state_t st;
  dspm_state_t next_state;
  logic [WAIT_W-1:0] wcnt;
  logic [WAIT_W-1:0] next_wcnt;
  logic [WAIT_W-1:0] wait_cnt;
  logic clk_off;
  logic boot_mode;
  logic boot_loaded;
  logic host_rdy;
  logic pin3_val;
  logic pin3_out;
  logic pin3_tsel;
  logic err_own;
  logic [1:0] acc_space;
  logic acc_write;
  logic acc_dma;
  logic [EXT_AW-1:0] acc_addr;
  logic [EXT_DW-1:0] acc_wdata;
  logic [EXT_DW-1:0] acc_rdata;
  logic [1:0] mcnt;
  logic [EXT_DW-1:0] dmaio_mem [DMAIO_DEPTH];

  wire apb_acc = psel & penable & ~pready;
  wire wr_en = apb_acc & pwrite;
  wire ext_mode = port_mode_pin; // R16
  wire mc_tick = mcnt == MCYC_LAST;
  wire [1:0] next_mcnt = mc_tick ? 2'h0 : mcnt + 2'h1;
  wire cmd_wr = wr_en & hit(paddr, OFF_CMD);
  wire [1:0] cmd_space = pwdata[CMD_SPACE_LSB +: 2];
  wire cmd_dmaio = pwdata[CMD_DMA_BIT] & (cmd_space == SP_IO);
  wire owner_ok = pwdata[CMD_SUB_BIT] == subsystem_select; // R10
  wire can_go = (st == ST_IDLE) & owner_ok & (cmd_dmaio | ext_mode);
  wire launch_ext = cmd_wr & can_go & ~cmd_dmaio;
  wire launch_dmaio = cmd_wr & can_go & cmd_dmaio; // R8
  wire refused = cmd_wr & ~can_go;
  wire chk_rdy = wait_cnt >= READY_MIN_WAIT; // R2
  wire waits_done = wcnt >= wait_cnt;
  wire [3:0] dmaio_idx = acc_addr[3:0];
  wire next_active = next_state != ST_IDLE;
  wire [1:0] next_space = launch_ext ? cmd_space : acc_space;
  wire next_write = launch_ext ? pwdata[CMD_WRITE_BIT] : acc_write;
  wire mapped = (paddr[1:0] == 2'h0) && (paddr <= OFF_HOSTIO);
  wire pin3_drive = pin3_tsel ? subsystem_a_timer_output : pin3_val; // R9
  wire [31:0] status_word = {26'h0, host_mux_select, dir_in, subsystem_select,
    port_mode_pin, err_own, st != ST_IDLE}; // R11
  wire [31:0] pmode_word = {24'h0, wait_cnt, 2'h0, boot_mode, clk_off};
  wire [31:0] hostio_word = {27'h0, subsystem_a_pin3_io_in, pin3_tsel, pin3_out,
    pin3_val, host_rdy};
  wire [31:0] read_mux =
    hit(paddr, OFF_PMODE) ? pmode_word :
    hit(paddr, OFF_CMD) ? {27'h0, subsystem_select, acc_dma, acc_write, acc_space} :
    hit(paddr, OFF_ADDR) ? {14'h0, acc_addr} :
    hit(paddr, OFF_WDATA) ? {16'h0, acc_wdata} :
    hit(paddr, OFF_RDATA) ? {16'h0, acc_rdata} :
    hit(paddr, OFF_STATUS) ? status_word :
    hit(paddr, OFF_HOSTIO) ? hostio_word : 32'h0;

  // access sequencer, paced by machine-cycle ticks
  always_comb
  begin
    next_state = st;
    next_wcnt = wcnt;
    unique case (st)
      ST_IDLE:
        if (launch_ext)
        begin
          next_state = ST_WAIT;
          next_wcnt = '0;
        end
      ST_WAIT:
        if (mc_tick)
        begin
          if (!waits_done)
            next_wcnt = wcnt + 4'h1;
          else if (!(chk_rdy && !ready_in)) // R1
            next_state = ST_DONE;
        end
      ST_DONE:
        if (mc_tick)
          next_state = ST_IDLE; // R19
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= ST_IDLE;
      wcnt <= '0;
      mcnt <= 2'h0;
      boot_loaded <= 1'b0;
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      st <= next_state;
      wcnt <= next_wcnt;
      mcnt <= next_mcnt;
      boot_loaded <= 1'b1; // straps taken at the first edge after release
      pready <= apb_acc; // one wait state on every transfer
      prdata <= (apb_acc && !pwrite) ? read_mux : 32'h0;
      pslverr <= apb_acc & ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_off <= 1'b0;
      boot_mode <= 1'b0;
      wait_cnt <= PM_WAIT_RST;
      host_rdy <= 1'b0;
      pin3_val <= 1'b0;
      pin3_out <= 1'b0;
      pin3_tsel <= 1'b0;
      acc_addr <= '0;
      acc_wdata <= '0;
    end
    else
    begin
      if (!boot_loaded)
        boot_mode <= boot_fn(port_mode_pin, host_mux_select, subsystem_select); // R12
      else if (wr_en && hit(paddr, OFF_PMODE))
        boot_mode <= pwdata[PM_BOOT_BIT];
      if (wr_en && hit(paddr, OFF_PMODE))
      begin
        clk_off <= pwdata[PM_CYCLE_CLOCK_DISABLE_BIT];
        wait_cnt <= pwdata[PM_WAIT_LSB +: WAIT_W];
      end
      if (wr_en && hit(paddr, OFF_HOSTIO))
      begin
        host_rdy <= pwdata[HIO_RDY_BIT];
        pin3_val <= pwdata[HIO_VAL_BIT];
        pin3_out <= pwdata[HIO_OUT_BIT];
        pin3_tsel <= pwdata[HIO_TSEL_BIT];
      end
      // address and data locked while an access runs
      if (wr_en && hit(paddr, OFF_ADDR) && st == ST_IDLE)
        acc_addr <= pwdata[EXT_AW-1:0];
      if (wr_en && hit(paddr, OFF_WDATA) && st == ST_IDLE)
        acc_wdata <= pwdata[EXT_DW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_space <= SP_PROG;
      acc_write <= 1'b0;
      acc_dma <= 1'b0;
      acc_rdata <= '0;
      err_own <= 1'b0;
    end
    else
    begin
      if (launch_ext || launch_dmaio)
      begin
        acc_space <= cmd_space;
        acc_write <= pwdata[CMD_WRITE_BIT];
        acc_dma <= pwdata[CMD_DMA_BIT];
      end
      if (launch_dmaio && !pwdata[CMD_WRITE_BIT])
        acc_rdata <= dmaio_mem[dmaio_idx];
      else if (st == ST_WAIT && next_state == ST_DONE && !acc_write)
        acc_rdata <= ext_rdata;
      // a refusal in the clearing cycle still sets the flag
      if (refused)
        err_own <= 1'b1;
      else if (wr_en && hit(paddr, OFF_STATUS) && pwdata[ST_ERR_BIT])
        err_own <= 1'b0;
    end
  end

  // dedicated DMA io space, no pins involved
  always_ff @(posedge pclk)
  begin
    if (launch_dmaio && pwdata[CMD_WRITE_BIT])
      dmaio_mem[dmaio_idx] <= acc_wdata; // R8
  end

  // pins, all registered; strobes, selects and direction from next-state values
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      program_space_select_n <= 1'b1;
      data_space_select_n <= 1'b1;
      memory_strobe_n <= 1'b1;
      mem_ctl_oe_n <= 1'b1;
      io_space_strobe_n <= 1'b1;
      io_space_strobe_oe_n <= 1'b1;
      dir_out <= 1'b1;
      dir_oe_n <= 1'b1;
      ready_out <= 1'b0;
      ready_oe_n <= 1'b1;
      ext_addr <= '0;
      ext_wdata <= '0;
      ext_data_oe_n <= 1'b1;
      machine_clock_output <= 1'b0;
      machine_clock_oe_n <= 1'b1;
    end
    else
    begin
      program_space_select_n <= ~(next_active & (next_space == SP_PROG)); // R17
      data_space_select_n <= ~(next_active & (next_space == SP_DATA)); // R17
      memory_strobe_n <= ~(next_active & (next_space != SP_IO));
      mem_ctl_oe_n <= ~ext_mode | ~output_disable_n; // R18
      io_space_strobe_n <= ext_mode ? ~(next_active & (next_space == SP_IO)) : pin3_drive; // R7 R9
      io_space_strobe_oe_n <= ~output_disable_n | (~ext_mode & ~pin3_out); // R13 R9
      dir_out <= ~(next_active & next_write); // R4
      dir_oe_n <= ~ext_mode | ~output_disable_n; // R5 R13
      ready_out <= host_rdy; // R6
      ready_oe_n <= ext_mode | ~output_disable_n; // R6
      ext_addr <= launch_ext ? acc_addr : ext_addr;
      ext_wdata <= launch_ext ? acc_wdata : ext_wdata;
      ext_data_oe_n <= ~(next_active & next_write & ext_mode);
      machine_clock_output <= next_mcnt >= MCYC_HALF; // R14
      machine_clock_oe_n <= clk_off | ~output_disable_n; // R15
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ready_check;
    st == ST_WAIT && mc_tick && waits_done && chk_rdy;
  endsequence
  sequence s_leave_done;
    st == ST_DONE && mc_tick;
  endsequence
  ready_stall_a: assert property (s_ready_check ##0 !ready_in |=> st == ST_WAIT) // R1
    else $error("access ended while ready was low");
  ready_ignore_a: assert property (st == ST_WAIT && mc_tick && waits_done && !chk_rdy
    |=> st == ST_DONE) // R2
    else $error("ready sampled with fewer than two waits");
  ready_done_a: assert property (s_ready_check ##0 ready_in |=> st == ST_DONE ##[1:4] st == ST_IDLE) // R19
    else $error("access did not finish after ready");
  strobe_release_a: assert property (s_leave_done |=> memory_strobe_n && program_space_select_n
    && data_space_select_n && dir_out) // R19
    else $error("strobes not released at access end");
  dir_write_a: assert property (!dir_out |-> acc_write && st != ST_IDLE) // R4
    else $error("direction low outside a write");
  io_cpu_a: assert property (st != ST_IDLE && !io_space_strobe_n |-> acc_space == SP_IO && !acc_dma) // R7
    else $error("io strobe for a non cpu io access");
  dmaio_internal_a: assert property (launch_dmaio |=> (st == ST_IDLE && memory_strobe_n) [*2]) // R8
    else $error("dma io access reached the pins");
  owner_check_a: assert property (cmd_wr && !owner_ok && st == ST_IDLE |=> st == ST_IDLE && err_own) // R10
    else $error("access by non-owning subsystem");
  float_off_a: assert property (!output_disable_n |=> dir_oe_n && io_space_strobe_oe_n
    && machine_clock_oe_n && ready_oe_n) // R13
    else $error("outputs driven while disabled");
  clk_stop_a: assert property (clk_off |=> machine_clock_oe_n) // R15
    else $error("machine clock driven while disabled");
  mclk_shape_a: assert property (mc_tick |=> !machine_clock_output ##2 machine_clock_output) // R14
    else $error("machine clock edge misplaced");
  host_pins_a: assert property (presetn && !port_mode_pin && output_disable_n |=> dir_oe_n && !ready_oe_n
    && mem_ctl_oe_n && ready_out == $past(host_rdy)) // R5
    else $error("host mode pin roles wrong");
  boot_strap_a: assert property ($rose(boot_loaded) |-> boot_mode
    == boot_fn($past(port_mode_pin), $past(host_mux_select), $past(subsystem_select))) // R12
    else $error("boot bit not taken from straps");
endmodule
`default_nettype wire
